// ==== verilog/rir_top.sv ====
`timescale 1ns/1ps
module rir_top (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Register port
   input wire logic [6:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // Device context
   input wire logic [1:0] i_data_mode,
   input wire logic [2:0] i_op_state,
   // Event sources
   input wire logic i_sleep_timer_on,
   input wire logic i_sleep_timer_expired,
   input wire logic i_receive_timer_on,
   input wire logic i_receive_timer_expired,
   input wire logic i_fsk_demod,
   input wire logic i_signal_above_trigger,
   input wire logic i_preamble_pass,
   input wire logic i_syncword_pass,
   input wire logic i_node_id_pass,
   input wire logic i_checksum_pass,
   input wire logic i_packet_received,
   input wire logic i_signal_indicator,
   input wire logic i_queue_not_empty,
   input wire logic i_queue_level_reached,
   input wire logic i_queue_full,
   input wire logic i_queue_byte_strobe,
   input wire logic i_queue_overflow_event,
   // Interrupt lines
   output logic o_irq_line_a,
   output logic o_irq_line_b
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0] enable_q;
   logic [7:0] select_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic line_a_q;
   logic line_b_q;
   logic [7:0] flags;
   logic [7:0] flag_set;
   logic [7:0] flag_clear;
   logic line_a_raw;
   logic line_b_raw;
   rir_pkg::rir_mode_t mode;

   rir_src_if src ();

   // ----------------------------------------------------------------
   // Context decode
   // ----------------------------------------------------------------
   assign mode = rir_pkg::rir_mode_t'(i_data_mode);

   wire packet_mode = (mode == rir_pkg::RIR_MODE_PACKET);
   wire queue_mode = (mode == rir_pkg::RIR_MODE_BUFFER) || packet_mode;

   // Clears only in standby, tune, receive or EEPROM
   wire clear_allowed = (i_op_state == rir_pkg::ST_STANDBY) ||
                        (i_op_state == rir_pkg::ST_TUNE) ||
                        (i_op_state == rir_pkg::ST_RECEIVE) ||
                        (i_op_state == rir_pkg::ST_EEPROM);

   // ----------------------------------------------------------------
   // Register write decode
   // ----------------------------------------------------------------
   wire wr_enable = i_reg_wr && (i_reg_addr == rir_pkg::ADDR_SOURCE_ENABLE);
   wire wr_select = i_reg_wr && (i_reg_addr == rir_pkg::ADDR_LINE_SELECT);
   wire wr_clear = i_reg_wr && (i_reg_addr == rir_pkg::ADDR_FLAG_CLEAR);

   // Clear bits follow flag order; a 0 leaves the flag
   assign flag_clear = (wr_clear && clear_allowed) ? i_reg_wdata : 8'h00;

   // Per source enables, reset to zero
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         enable_q <= rir_pkg::RST_SOURCE_ENABLE;
      else if (wr_enable)
         enable_q <= i_reg_wdata;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         select_q <= rir_pkg::RST_LINE_SELECT;
      else if (wr_select)
         select_q <= i_reg_wdata;
   end

   // ----------------------------------------------------------------
   // Flag set conditions
   // ----------------------------------------------------------------
   // Timer expiry only while the timer runs
   assign flag_set[rir_pkg::BIT_SLEEP] = i_sleep_timer_on &&
      i_sleep_timer_expired && enable_q[rir_pkg::BIT_SLEEP];
   assign flag_set[rir_pkg::BIT_RECEIVE] = i_receive_timer_on &&
      i_receive_timer_expired && enable_q[rir_pkg::BIT_RECEIVE];

   // Strength above trigger in FSK demodulation
   assign flag_set[rir_pkg::BIT_SIGNAL] = i_fsk_demod &&
      i_signal_above_trigger && enable_q[rir_pkg::BIT_SIGNAL];

   assign flag_set[rir_pkg::BIT_PREAMBLE] = i_preamble_pass &&
      enable_q[rir_pkg::BIT_PREAMBLE];

   assign flag_set[rir_pkg::BIT_SYNCWORD] = i_syncword_pass &&
      enable_q[rir_pkg::BIT_SYNCWORD];

   // Node id pass, packet mode only
   assign flag_set[rir_pkg::BIT_NODE_ID] = i_node_id_pass && packet_mode &&
      enable_q[rir_pkg::BIT_NODE_ID];

   assign flag_set[rir_pkg::BIT_CHECKSUM] = i_checksum_pass &&
      packet_mode && enable_q[rir_pkg::BIT_CHECKSUM];

   assign flag_set[rir_pkg::BIT_PACKET] = i_packet_received &&
      packet_mode && enable_q[rir_pkg::BIT_PACKET];

   rir_flag_bank u_flags (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_set(flag_set),
      .i_clear(flag_clear),
      .o_flags(flags)
   );

   // ----------------------------------------------------------------
   // Line sources
   // ----------------------------------------------------------------
   assign src.flags = flags;
   assign src.mode = mode;
   assign src.signal_indicator = i_signal_indicator;
   // Queue levels pass straight through, gated off in direct mode
   assign src.queue_not_empty = i_queue_not_empty && queue_mode;
   assign src.queue_level_reached = i_queue_level_reached && queue_mode;
   assign src.queue_full = i_queue_full && queue_mode;
   assign src.queue_overflow_event = i_queue_overflow_event && queue_mode;
   // Byte strobe kept as a pulse, never latched
   assign src.queue_byte_strobe = i_queue_byte_strobe && queue_mode;

   rir_line_mux u_mux (
      .src(src),
      .i_sel_a(select_q[rir_pkg::SEL_A_LSB +: 4]),
      .i_sel_b(select_q[rir_pkg::SEL_B_LSB +: 4]),
      .o_line_a(line_a_raw),
      .o_line_b(line_b_raw)
   );

   // Registered lines; adds one cycle but no glitches at the pins
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         line_a_q <= 1'b0;
         line_b_q <= 1'b0;
      end
      else
      begin
         line_a_q <= line_a_raw;
         line_b_q <= line_b_raw;
      end
   end

   assign o_irq_line_a = line_a_q;
   assign o_irq_line_b = line_b_q;

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   // Status shows only the eight flags, no byte strobe bit
   wire [7:0] rd_mux = (i_reg_addr == rir_pkg::ADDR_SOURCE_ENABLE) ? enable_q :
                       (i_reg_addr == rir_pkg::ADDR_LINE_SELECT) ? select_q :
                       (i_reg_addr == rir_pkg::ADDR_FLAG_STATUS) ? flags :
                       8'h00;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= i_reg_rd;
         if (i_reg_rd)
            rdata_q <= rd_mux;
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_reg_rvalid = rvalid_q;

endmodule : rir_top

// ==== verilog/rir_pkg.sv ====
package rir_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_SOURCE_ENABLE = 7'h3f;
   localparam logic [6:0] ADDR_LINE_SELECT = 7'h41;
   localparam logic [6:0] ADDR_FLAG_CLEAR = 7'h42;
   localparam logic [6:0] ADDR_FLAG_STATUS = 7'h43;

   localparam logic [7:0] RST_SOURCE_ENABLE = 8'h00;
   localparam logic [7:0] RST_LINE_SELECT = 8'h00;
   localparam logic [7:0] RST_FLAGS = 8'h00;

   localparam int SEL_B_LSB = 4;
   localparam int SEL_A_LSB = 0;

   // ----------------------------------------------------------------
   // Flag bit positions
   // ----------------------------------------------------------------
   localparam int BIT_SLEEP = 7;
   localparam int BIT_RECEIVE = 6;
   localparam int BIT_SIGNAL = 5;
   localparam int BIT_PREAMBLE = 4;
   localparam int BIT_SYNCWORD = 3;
   localparam int BIT_NODE_ID = 2;
   localparam int BIT_CHECKSUM = 1;
   localparam int BIT_PACKET = 0;

   // ----------------------------------------------------------------
   // Modes and device states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RIR_MODE_DIRECT = 2'b00,
      RIR_MODE_BUFFER = 2'b01,
      RIR_MODE_PACKET = 2'b10,
      RIR_MODE_RSVD = 2'b11
   } rir_mode_t;

   localparam logic [2:0] ST_SLEEP = 3'h0;
   localparam logic [2:0] ST_STANDBY = 3'h1;
   localparam logic [2:0] ST_TUNE = 3'h2;
   localparam logic [2:0] ST_RECEIVE = 3'h3;
   localparam logic [2:0] ST_EEPROM = 3'h4;

endpackage : rir_pkg

// ==== verilog/rir_src_if.sv ====
`timescale 1ns/1ps
// Candidate sources for the two interrupt lines
interface rir_src_if;
   logic [7:0] flags;
   logic signal_indicator;
   logic queue_not_empty;
   logic queue_level_reached;
   logic queue_full;
   logic queue_byte_strobe;
   logic queue_overflow_event;
   rir_pkg::rir_mode_t mode;

   modport src (
      output flags, signal_indicator, queue_not_empty, queue_level_reached,
      output queue_full, queue_byte_strobe, queue_overflow_event, mode
   );
   modport sink (
      input flags, signal_indicator, queue_not_empty, queue_level_reached,
      input queue_full, queue_byte_strobe, queue_overflow_event, mode
   );
endinterface : rir_src_if

// ==== verilog/rir_flag_bank.sv ====
`timescale 1ns/1ps
module rir_flag_bank (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_set,
   input wire logic [7:0] i_clear,
   output logic [7:0] o_flags
);
   logic [7:0] flags_q;
   logic [7:0] flags_d;

   // ----------------------------------------------------------------
   // Sticky flags
   // ----------------------------------------------------------------
   // Held until cleared
   // Set wins over a same-cycle clear so no event is lost
   assign flags_d = (flags_q & ~i_clear) | i_set;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         flags_q <= rir_pkg::RST_FLAGS;
      else
         flags_q <= flags_d;
   end

   assign o_flags = flags_q;
endmodule : rir_flag_bank

// ==== verilog/rir_line_mux.sv ====
`timescale 1ns/1ps
module rir_line_mux (
   rir_src_if.sink src,
   input wire logic [3:0] i_sel_a,
   input wire logic [3:0] i_sel_b,
   output logic o_line_a,
   output logic o_line_b
);
   // ----------------------------------------------------------------
   // Mode dependent source map
   // ----------------------------------------------------------------
   function automatic logic pick(input logic [3:0] code);
      logic r;
      r = 1'b0;
      if (code == 4'h1)
         r = src.flags[rir_pkg::BIT_SIGNAL];
      else if (code == 4'h2)
         r = src.flags[rir_pkg::BIT_PREAMBLE];
      else if (code == 4'h3)
         r = src.flags[rir_pkg::BIT_SYNCWORD];
      else
      begin
         unique case (src.mode)
            // Direct mode map, queue sources absent
            rir_pkg::RIR_MODE_DIRECT:
               unique case (code)
                  4'h4: r = src.flags[rir_pkg::BIT_SLEEP];
                  4'h5: r = src.flags[rir_pkg::BIT_RECEIVE];
                  4'h6: r = src.signal_indicator;
                  default: r = 1'b0;
               endcase
            rir_pkg::RIR_MODE_BUFFER:
               unique case (code)
                  4'h4: r = src.flags[rir_pkg::BIT_SLEEP];
                  4'h5: r = src.flags[rir_pkg::BIT_RECEIVE];
                  4'h6: r = src.queue_not_empty;
                  4'h7: r = src.queue_level_reached;
                  4'h8: r = src.queue_full;
                  4'h9: r = src.queue_byte_strobe;
                  4'ha: r = src.queue_overflow_event;
                  4'hb: r = src.signal_indicator;
                  default: r = 1'b0;
               endcase
            rir_pkg::RIR_MODE_PACKET:
               unique case (code)
                  4'h4: r = src.flags[rir_pkg::BIT_NODE_ID];
                  4'h5: r = src.flags[rir_pkg::BIT_CHECKSUM];
                  4'h6: r = src.flags[rir_pkg::BIT_PACKET];
                  4'h7: r = src.flags[rir_pkg::BIT_SLEEP];
                  4'h8: r = src.flags[rir_pkg::BIT_RECEIVE];
                  4'h9: r = src.queue_not_empty;
                  4'ha: r = src.queue_level_reached;
                  4'hb: r = src.queue_full;
                  4'hc: r = src.queue_byte_strobe;
                  4'hd: r = src.queue_overflow_event;
                  4'he: r = src.signal_indicator;
                  // Code 1111 and 0000 stay low
                  default: r = 1'b0;
               endcase
            default: r = 1'b0;
         endcase
      end
      return r;
   endfunction : pick

   assign o_line_a = pick(i_sel_a);
   assign o_line_b = pick(i_sel_b);
endmodule : rir_line_mux

// ==== bench/rir_checker.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// Line routing and register port properties
// ---------------------------------------------
module rir_checker (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [6:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   input wire logic [1:0] i_data_mode,
   input wire logic i_signal_indicator,
   input wire logic i_queue_byte_strobe,
   input wire logic o_irq_line_a,
   input wire logic o_irq_line_b
);
   logic [7:0] sel_q;
   // Shadow of the selector, since the checker cannot read it back
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         sel_q <= 8'h00;
      else if (i_reg_wr && i_reg_addr == 7'h41)
         sel_q <= i_reg_wdata;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_b_off;
      sel_q[7:4] == 4'h0 |=> !o_irq_line_b;
   endproperty
   a_b_off: assert property (p_b_off) else $error("line b high");
   property p_a_top;
      sel_q[3:0] == 4'hf |=> !o_irq_line_a;
   endproperty
   a_a_top: assert property (p_a_top) else $error("line a high");
   property p_ind_direct;
      sel_q[3:0] == 4'h6 && i_data_mode == 2'h0
         |=> o_irq_line_a == $past(i_signal_indicator);
   endproperty
   a_ind_direct: assert property (p_ind_direct) else $error("ind");
   property p_direct_zero;
      i_data_mode == 2'h0 && sel_q[7:4] >= 4'h7 && sel_q[7:4] <= 4'he
         |=> !o_irq_line_b;
   endproperty
   a_direct_zero: assert property (p_direct_zero) else $error("dz");
   property p_byte_buffer;
      sel_q[7:4] == 4'h9 && i_data_mode == 2'h1
         |=> o_irq_line_b == $past(i_queue_byte_strobe);
   endproperty
   a_byte_buffer: assert property (p_byte_buffer) else $error("bb");
   property p_byte_packet;
      sel_q[3:0] == 4'hc && i_data_mode == 2'h2
         |=> o_irq_line_a == $past(i_queue_byte_strobe);
   endproperty
   a_byte_packet: assert property (p_byte_packet) else $error("bp");
   property p_buf_zero;
      i_data_mode == 2'h1 && sel_q[3:0] >= 4'hc && sel_q[3:0] <= 4'he
         |=> !o_irq_line_a;
   endproperty
   a_buf_zero: assert property (p_buf_zero) else $error("buf zero");
   property p_clear_rd;
      i_reg_rd && i_reg_addr == 7'h42 |=> o_reg_rdata == 8'h00;
   endproperty
   a_clear_rd: assert property (p_clear_rd) else $error("clear rd");
   property p_rd_ans;
      i_reg_rd |=> o_reg_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("no rvalid");
endmodule : rir_checker

// ==== bench/rir_mcu_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// Host controller on the register port
// ---------------------------------------------
module rir_mcu_model (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   output logic [6:0] o_addr,
   output logic o_wr,
   output logic [7:0] o_wdata,
   output logic o_rd
);
   initial
   begin
      o_addr = 7'h00;
      o_wr = 1'b0;
      o_wdata = 8'h00;
      o_rd = 1'b0;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      // Idle bus shows the inverse so stale values are never trusted
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      #1;
      d = i_rvalid ? i_rdata : 8'hxx;
   endtask : rd
endmodule : rir_mcu_model

// ==== bench/test_rir_top.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// Self-checking bench
// ---------------------------------------------
module test_rir_top;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [6:0] i_reg_addr;
   logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_irq_line_a, o_irq_line_b;
   logic [7:0] i_reg_wdata, o_reg_rdata;
   logic [1:0] i_data_mode = 2'h0;
   logic [2:0] i_op_state = 3'h1;
   logic [7:0] ev = 8'h00;
   logic t_on = 1'b0;
   logic [5:0] raw = 6'h00;
   int error_cnt = 0;
   int compares = 0;
   rir_top u_dut (.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
      .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_data_mode, .i_op_state,
      .i_sleep_timer_on(t_on), .i_sleep_timer_expired(ev[7]),
      .i_receive_timer_on(t_on), .i_receive_timer_expired(ev[6]),
      .i_fsk_demod(t_on), .i_signal_above_trigger(ev[5]),
      .i_preamble_pass(ev[4]), .i_syncword_pass(ev[3]),
      .i_node_id_pass(ev[2]), .i_checksum_pass(ev[1]),
      .i_packet_received(ev[0]), .i_signal_indicator(raw[0]),
      .i_queue_not_empty(raw[1]), .i_queue_level_reached(raw[2]),
      .i_queue_full(raw[3]), .i_queue_overflow_event(raw[4]),
      .i_queue_byte_strobe(raw[5]), .o_irq_line_a, .o_irq_line_b);
   rir_mcu_model u_mcu (.i_clk, .i_rdata(o_reg_rdata),
      .i_rvalid(o_reg_rvalid), .o_addr(i_reg_addr), .o_wr(i_reg_wr),
      .o_wdata(i_reg_wdata), .o_rd(i_reg_rd));
   initial
      forever #4 i_clk = ~i_clk;
   task automatic complete_run;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic pulse(input logic [7:0] e, input logic on);
      @(posedge i_clk);
      ev <= e;
      t_on <= on;
      @(posedge i_clk);
      ev <= 8'h00;
      t_on <= 1'b0;
   endtask : pulse
   // Raw order: indicator, not empty, level, full, overflow, byte strobe
   function automatic logic pick(input logic [1:0] m, input logic [3:0] c,
      input logic [7:0] f, input logic [5:0] r);
      logic [15:0] v;
      if (m == 2'h0)
         v = {9'h000, r[0], f[6], f[7], f[3], f[4], f[5], 1'b0};
      else if (m == 2'h1)
         v = {4'h0, r[0], r[4], r[5], r[3], r[2], r[1], f[6], f[7],
            f[3], f[4], f[5], 1'b0};
      else if (m == 2'h2)
         v = {1'b0, r[0], r[4], r[5], r[3], r[2], r[1], f[6], f[7],
            f[0], f[1], f[2], f[3], f[4], f[5], 1'b0};
      else
         // Reserved mode keeps only the three common codes
         v = {12'h000, f[3], f[4], f[5], 1'b0};
      return v[c];
   endfunction : pick
   task automatic t_reset;
      logic [7:0] d;
      u_mcu.rd(7'h3f, d);
      check(d, 8'h00);
      u_mcu.rd(7'h41, d);
      check(d, 8'h00);
      u_mcu.rd(7'h43, d);
      check(d, 8'h00);
      u_mcu.rd(7'h42, d);
      check(d, 8'h00);
   endtask : t_reset
   task automatic t_gate;
      logic [7:0] d;
      @(posedge i_clk);
      i_data_mode <= 2'h1;
      pulse(8'hff, 1'b1);
      u_mcu.rd(7'h43, d);
      check(d, 8'h00);
      u_mcu.wr(7'h3f, 8'hff);
      u_mcu.rd(7'h3f, d);
      check(d, 8'hff);
      pulse(8'h00, 1'b1);
      u_mcu.rd(7'h43, d);
      check(d, 8'h00);
      pulse(8'hff, 1'b0);
      u_mcu.rd(7'h43, d);
      check(d, 8'h18);
      pulse(8'hff, 1'b1);
      u_mcu.rd(7'h43, d);
      check(d, 8'hf8);
   endtask : t_gate
   task automatic t_clear;
      logic [7:0] d;
      @(posedge i_clk);
      i_data_mode <= 2'h2;
      for (int s = 0; s < 8; s++)
      begin
         @(posedge i_clk);
         i_op_state <= 3'(s);
         pulse(8'hff, 1'b1);
         u_mcu.wr(7'h42, 8'hff);
         u_mcu.rd(7'h43, d);
         check(d, (s >= 1 && s <= 4) ? 8'h00 : 8'hff);
      end
      @(posedge i_clk);
      i_op_state <= 3'h1;
      u_mcu.wr(7'h42, 8'h5a);
      u_mcu.rd(7'h43, d);
      check(d, 8'ha5);
      u_mcu.wr(7'h42, 8'h00);
      u_mcu.rd(7'h43, d);
      check(d, 8'ha5);
      // Event held across the clear edge must survive it
      @(posedge i_clk);
      ev <= 8'h01;
      u_mcu.wr(7'h42, 8'h01);
      ev <= 8'h00;
      u_mcu.rd(7'h43, d);
      check(d, 8'ha5);
   endtask : t_clear
   // Each code of each mode, with the raw pattern and its inverse
   task automatic t_map;
      logic [7:0] d;
      logic [5:0] r;
      for (int p = 0; p < 2; p++)
         for (int m = 0; m < 4; m++)
            for (int c = 0; c < 16; c++)
            begin
               r = (p == 0) ? 6'h35 : 6'h0a;
               @(posedge i_clk);
               i_data_mode <= 2'(m);
               raw <= {1'b0, r[4:0]};
               u_mcu.wr(7'h41, {4'(15 - c), 4'(c)});
               @(posedge i_clk);
               raw[5] <= r[5];
               @(posedge i_clk);
               raw[5] <= 1'b0;
               #1;
               check({7'h00, o_irq_line_a},
                  {7'h00, pick(2'(m), 4'(c), 8'ha5, r)});
               check({7'h00, o_irq_line_b},
                  {7'h00, pick(2'(m), 4'(15 - c), 8'ha5, r)});
            end
      u_mcu.rd(7'h43, d);
      check(d, 8'ha5);
   endtask : t_map
   // Mid-run reset with live selection and flags
   task automatic t_rerun;
      u_mcu.wr(7'h41, 8'h11);
      repeat (2) @(posedge i_clk);
      #1;
      check({6'h00, o_irq_line_b, o_irq_line_a}, 8'h03);
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      #1;
      check({6'h00, o_irq_line_b, o_irq_line_a}, 8'h00);
      t_reset();
   endtask : t_rerun
   initial
   begin
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_reset();
      t_gate();
      t_clear();
      t_map();
      t_rerun();
      complete_run();
   end
   // Whole sequence needs about eight hundred cycles
   initial
   begin
      repeat (20000) @(posedge i_clk);
      error_cnt++;
      complete_run();
   end
endmodule : test_rir_top
bind rir_top rir_checker u_chk (.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr,
   .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_data_mode,
   .i_signal_indicator, .i_queue_byte_strobe, .o_irq_line_a, .o_irq_line_b);
